// >>> rtl/iebk_top.sv
// Interrupt enable bank: enables, request flags, priority gate and bus slave
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
module iebk_top (
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_i,
  input  wire logic                                      wb_cyc_i,
  input  wire logic                                      wb_stb_i,
  input  wire logic                                      wb_we_i,
  input  wire logic [iebk_pkg::ADR_W-1:0]                wb_adr_i,
  input  wire logic [31:0]                               wb_dat_i,
  input  wire logic [3:0]                                wb_sel_i,
  input  wire logic [iebk_pkg::NSRC-1:0]                 src_req_i,
  input  wire logic [iebk_pkg::NSRC*iebk_pkg::PRIO_W-1:0] src_prio_i,
  output logic      [31:0]                               wb_dat_o,
  output logic                                           wb_ack_o,
  output logic      [iebk_pkg::NSRC-1:0]                 arb_req_o,
  output logic      [iebk_pkg::NSRC*iebk_pkg::PRIO_W-1:0] arb_prio_o,
  output logic                                           irq_o
);
  import iebk_pkg::*;

  logic              acc;
  logic              wr;
  logic              hit;
  iebk_rgn_t         rgn;
  logic [2:0]        idx;
  logic [15:0]       lane;
  logic [NSRC-1:0]   en_all;
  logic [NSRC-1:0]   flag_all;
  logic [NSRC-1:0]   prio_live;
  logic [NSRC-1:0]   req_d;
  logic [NSRC-1:0]   req_q;
  logic [NSRC*PRIO_W-1:0] prio_q;
  logic              irq_q;
  logic [15:0]       rd_d;
  logic [31:0]       dat_q;
  logic [NREG-1:0]   en_wr;
  logic [NREG-1:0]   clr_wr;

  // Bus handshake and decode
  iebk_wb_slave u_slave (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc_i   (wb_cyc_i),
    .stb_i   (wb_stb_i),
    .we_i    (wb_we_i),
    .adr_i   (wb_adr_i),
    .ack_q_o (wb_ack_o),
    .acc_o   (acc),
    .wr_o    (wr),
    .hit_o   (hit),
    .rgn_o   (rgn),
    .idx_o   (idx)
  );

  // Registers are 16 bits wide: only the two low byte lanes matter
  assign lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // One bank per enable register, each with its own implemented mask
  generate
    for (genvar g = 0; g < NREG; g++)
    begin : g_bank
      assign en_wr[g] = wr && hit && (rgn == IEBK_RGN_EN) && (idx == 3'(g));
      assign clr_wr[g] = wr && hit && (rgn == IEBK_RGN_CLR) && (idx == 3'(g));
      iebk_bank #(
        .IMPL (IMPL_ALL[g*REG_W +: REG_W])
      ) u_bank (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .en_wr_i  (en_wr[g]),
        .clr_wr_i (clr_wr[g]),
        .wdata_i  (wb_dat_i[15:0]),
        .lane_i   (lane),
        .src_i    (src_req_i[g*REG_W +: REG_W]),
        .en_q_o   (en_all[g*REG_W +: REG_W]),
        .flag_q_o (flag_all[g*REG_W +: REG_W])
      );
    end
  endgenerate

  // A source with priority code zero is off whatever its enable says
  generate
    for (genvar s = 0; s < NSRC; s++)
    begin : g_src
      assign prio_live[s] = src_prio_i[s*PRIO_W +: PRIO_W] != PRIO_OFF;
      assign req_d[s] = flag_all[s] && en_all[s] && prio_live[s];
    end
  endgenerate

  // Registered request vector; the arbiter compares priorities downstream
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_q <= '0;
      prio_q <= '0;
    end
    else
    begin
      req_q <= req_d;
      prio_q <= src_prio_i;
    end
  end

  // Level interrupt while any gated request stands
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_q <= 1'b0;
    else
      irq_q <= |req_d;
  end

  // Read mux; clear region and misses read as zero
  always_comb
  begin
    rd_d = 16'h0000;
    if (hit)
    begin
      unique case (rgn)
        IEBK_RGN_EN:  rd_d = en_all[idx*REG_W +: REG_W];
        IEBK_RGN_FLG: rd_d = flag_all[idx*REG_W +: REG_W];
        IEBK_RGN_CLR: rd_d = 16'h0000;
      endcase
    end
  end

  // Read data captured with ack, upper half always zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h0000_0000;
    else if (acc)
      dat_q <= {16'h0000, rd_d};
  end

  assign wb_dat_o = dat_q;
  assign arb_req_o = req_q;
  assign arb_prio_o = prio_q;
  assign irq_o = irq_q;

  // Checks -----------------------------------------------------------
  localparam logic [NSRC-1:0] IMPL_V = IMPL_ALL;

  // A request reaches the arbiter only if enabled the cycle before
  property p_en_gate;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> ((arb_req_o & ~$past(en_all)) == '0);
  endproperty
  a_en_gate: assert property (p_en_gate)
    else $error("request passed a disabled source");

  // Unimplemented positions never hold a one
  property p_unimpl_zero;
    @(posedge clk_i) disable iff (rst_i)
      ((en_all & ~IMPL_V) == '0) && ((flag_all & ~IMPL_V) == '0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit set");

  // Upper half of read data is zero whenever answered
  property p_read_upper;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000);
  endproperty
  a_read_upper: assert property (p_read_upper)
    else $error("read data upper half not zero");

  // Everything disabled right after reset
  property p_reset_clear;
    @(posedge clk_i)
      $past(rst_i) |-> (en_all == '0) && !irq_o && (arb_req_o == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  // Full-lane enable write reads back masked one cycle later
  property p_write_back;
    logic [2:0] i;
    logic [15:0] v;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit && rgn == IEBK_RGN_EN && wb_sel_i[1:0] == 2'b11, i = idx, v = wb_dat_i[15:0])
      |=> en_all[i*REG_W +: REG_W] == (v & IMPL_ALL[i*REG_W +: REG_W]);
  endproperty
  a_write_back: assert property (p_write_back)
    else $error("enable write not stored");

  // Source pulse on an implemented bit sets its flag
  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ((flag_all & ($past(src_req_i) & IMPL_V)) == ($past(src_req_i) & IMPL_V));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("request did not set its flag");

  // Priority zero keeps the source away from the arbiter
  property p_prio_off;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ((arb_req_o & ~$past(prio_live)) == '0);
  endproperty
  a_prio_off: assert property (p_prio_off)
    else $error("priority zero source requested");

  // Without a clear write, a set flag stays set
  property p_flag_keep;
    @(posedge clk_i) disable iff (rst_i)
      (clr_wr == '0) |=> ((flag_all & $past(flag_all)) == $past(flag_all));
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("flag lost without a clear");

  // Request output equals flag and enable and live priority
  property p_req_and;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> arb_req_o == ($past(flag_all) & $past(en_all) & $past(prio_live));
  endproperty
  a_req_and: assert property (p_req_and)
    else $error("request vector mismatch");

  // Interrupt line tracks any standing request
  property p_irq_any;
    @(posedge clk_i) disable iff (rst_i)
      irq_o == (|arb_req_o);
  endproperty
  a_irq_any: assert property (p_irq_any)
    else $error("interrupt line disagrees with requests");

  // Ack is a single-cycle answer in the cycle after a request
  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack timing wrong");

  // No request, no answer in the next cycle
  property p_ack_idle;
    @(posedge clk_i) disable iff (rst_i)
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("ack without a request");

  // Every ack answers a request of the cycle before
  property p_ack_cause;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack with no request before it");

  // Read data only moves when a new request is taken
  property p_dat_hold;
    @(posedge clk_i) disable iff (rst_i)
      !acc |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data changed without a request");

  // Misses read as zero, whole word
  property p_miss_read;
    @(posedge clk_i) disable iff (rst_i)
      (acc && !wb_we_i && !hit) |=> (wb_dat_o == 32'h0000_0000);
  endproperty
  a_miss_read: assert property (p_miss_read)
    else $error("unmapped read not zero");

  // Clear region is write-only and reads as zero
  property p_clr_read;
    @(posedge clk_i) disable iff (rst_i)
      (acc && !wb_we_i && rgn == IEBK_RGN_CLR) |=> (wb_dat_o == 32'h0000_0000);
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("clear region read not zero");

  // No write lands in the taking cycle, so the answer is the stored value
  property p_en_read;
    logic [2:0] i;
    @(posedge clk_i) disable iff (rst_i)
      (acc && !wb_we_i && hit && rgn == IEBK_RGN_EN, i = idx)
      |=> (wb_dat_o[15:0] == en_all[i*REG_W +: REG_W]);
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable read differs from stored value");

  // Enables only move on an enable write
  property p_en_hold;
    @(posedge clk_i) disable iff (rst_i)
      (en_wr == '0) |=> (en_all == $past(en_all));
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("enable changed without a write");

  // All enables off keeps the interrupt line low
  property p_off_quiet;
    @(posedge clk_i) disable iff (rst_i)
      (en_all == '0) |=> !irq_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("interrupt with every source disabled");

  // A flag only rises where its source requested
  property p_flag_no_src;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ((flag_all & ~$past(flag_all) & ~$past(src_req_i)) == '0);
  endproperty
  a_flag_no_src: assert property (p_flag_no_src)
    else $error("flag set without a request");

  // Flag region is status only; a write there changes nothing
  property p_flag_ro;
    @(posedge clk_i) disable iff (rst_i)
      (wr && rgn == IEBK_RGN_FLG && src_req_i == '0) |=> (flag_all == $past(flag_all));
  endproperty
  a_flag_ro: assert property (p_flag_ro)
    else $error("flag region write changed a flag");

  // Full-lane clear with no competing request drops the named flags
  property p_flag_clear;
    logic [2:0] i;
    logic [15:0] v;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit && rgn == IEBK_RGN_CLR && wb_sel_i[1:0] == 2'b11 && src_req_i == '0,
       i = idx, v = wb_dat_i[15:0])
      |=> ((flag_all[i*REG_W +: REG_W] & v) == 16'h0000);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("clear write left a flag set");

  // Priority travels to the arbiter one cycle late
  property p_prio_copy;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (arb_prio_o == $past(src_prio_i));
  endproperty
  a_prio_copy: assert property (p_prio_copy)
    else $error("priority copy mismatch");

  // Main scenarios
  c_en_write: cover property (@(posedge clk_i) disable iff (rst_i) en_wr != '0);
  c_irq_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_clear: cover property (@(posedge clk_i) disable iff (rst_i) clr_wr != '0 ##2 !irq_o);
  c_masked_flag: cover property (@(posedge clk_i) disable iff (rst_i) (flag_all & ~en_all) != '0);
  c_prio_block: cover property (@(posedge clk_i) disable iff (rst_i) (flag_all & en_all & ~prio_live) != '0);
endmodule : iebk_top

// >>> rtl/iebk_pkg.sv
// Constants, register map and field layout of the interrupt enable bank
package iebk_pkg;
  localparam int unsigned NREG = 6;
  localparam int unsigned REG_W = 16;
  localparam int unsigned NSRC = NREG * REG_W;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned ADR_W = 8;

  // Byte offsets: enables, flag status (read-only), flag clear (write-one-to-clear)
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_FLAG = 8'h20;
  localparam logic [7:0] OFS_CLEAR = 8'h40;
  localparam logic [7:0] REGION_MASK = 8'he0;

  // Implemented positions per register
  localparam logic [15:0] IMPL_CTRL_1 = 16'h001f;
  localparam logic [15:0] IMPL_CTRL_2 = 16'h7ff3;
  localparam logic [15:0] IMPL_CTRL_3 = 16'h6066;
  localparam logic [15:0] IMPL_CTRL_4 = 16'he10e;
  localparam logic [15:0] IMPL_CTRL_5 = 16'h33ce;
  localparam logic [15:0] IMPL_CTRL_6 = 16'h0790;
  localparam logic [95:0] IMPL_ALL = {IMPL_CTRL_6, IMPL_CTRL_5, IMPL_CTRL_4,
                                      IMPL_CTRL_3, IMPL_CTRL_2, IMPL_CTRL_1};

  // Values after reset, and the priority code that turns a source off
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [2:0] PRIO_OFF = 3'h0;

  // Selected register region
  typedef enum logic [2:0] {
    IEBK_RGN_EN  = 3'b001,
    IEBK_RGN_FLG = 3'b010,
    IEBK_RGN_CLR = 3'b100
  } iebk_rgn_t;
endpackage : iebk_pkg

// >>> rtl/iebk_bank.sv
// One 16-bit enable register with its sticky request flags
module iebk_bank
  import iebk_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'hffff
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        en_wr_i,
  input  wire logic        clr_wr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [15:0] lane_i,
  input  wire logic [15:0] src_i,
  output logic      [15:0] en_q_o,
  output logic      [15:0] flag_q_o
);
  logic [15:0] clr;

  // Enable store; unimplemented bits never take a write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      en_q_o <= ENABLE_RST;
    else if (en_wr_i)
      en_q_o <= (en_q_o & ~(lane_i & IMPL)) | (wdata_i & lane_i & IMPL);
  end

  // Set beats clear so a request in the clear cycle survives
  assign clr = clr_wr_i ? (wdata_i & lane_i) : 16'h0000;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_q_o <= FLAG_RST;
    else
      flag_q_o <= ((flag_q_o & ~clr) | src_i) & IMPL;
  end
endmodule : iebk_bank

// >>> rtl/iebk_wb_slave.sv
// Classic Wishbone handshake and address decode for the bank
module iebk_wb_slave
  import iebk_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [iebk_pkg::ADR_W-1:0] adr_i,
  output logic                           ack_q_o,
  output logic                           acc_o,
  output logic                           wr_o,
  output logic                           hit_o,
  output iebk_pkg::iebk_rgn_t            rgn_o,
  output logic      [2:0]                idx_o
);
  logic [7:0] word;

  // One wait state: ack rises the cycle after the request, drops after one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q_o <= 1'b0;
    else
      ack_q_o <= cyc_i && stb_i && !ack_q_o;
  end

  assign acc_o = cyc_i && stb_i && !ack_q_o;
  // Write lands on the edge where the master sees ack
  assign wr_o = cyc_i && stb_i && we_i && ack_q_o;

  // Decode region and word index; misaligned or past-end words miss
  assign word = adr_i & ~REGION_MASK;
  assign idx_o = word[4:2];
  always_comb
  begin
    unique case (adr_i & REGION_MASK)
      OFS_FLAG:  rgn_o = IEBK_RGN_FLG;
      OFS_CLEAR: rgn_o = IEBK_RGN_CLR;
      default:   rgn_o = IEBK_RGN_EN;
    endcase
  end
  assign hit_o = (word[1:0] == 2'h0) && (idx_o < 3'(NREG)) &&
                 ((adr_i & REGION_MASK) inside {OFS_ENABLE, OFS_FLAG, OFS_CLEAR});
endmodule : iebk_wb_slave

// >>> dv/iebk_src_model.sv
// Peripheral request sources for the interrupt enable bank
module iebk_src_model
  import iebk_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic [iebk_pkg::NSRC-1:0] fire_i,
  output logic      [iebk_pkg::NSRC-1:0] src_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered, so a request changes just after an edge; idle sources sit low
  // External inputs are taken as already routed to a remap pin by software
  always_ff @(posedge clk_i)
  begin
    src_req_o <= fire_i;
  end
endmodule : iebk_src_model

// >>> dv/iebk_top_tb.sv
// Self-checking bench for the interrupt enable bank
module iebk_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iebk_pkg::*;
  logic                   clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [7:0]             adr;
  logic [3:0]             sel;
  logic [31:0]            dat_w, dat_r, rd;
  logic [NSRC-1:0]        fire, src_req, arb_req;
  logic [NSRC*PRIO_W-1:0] prio, arb_prio;
  int                     n_mismatch = 0;
  int                     num_checks = 0;

  iebk_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel), .src_req_i(src_req), .src_prio_i(prio),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .arb_req_o(arb_req), .arb_prio_o(arb_prio), .irq_o(irq));
  iebk_src_model u_src (.clk_i(clk_i), .fire_i(fire), .src_req_o(src_req));

  // 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (ack === 1'b1)
        break;
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      $display("MISMATCH bus ack expected 1 seen 0");
      print_verdict();
    end
  endtask : bus

  task automatic do_reset();
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
  endtask : do_reset

  // Reset values, implemented masks, read-back, reset in mid-run
  task automatic t_regs();
    logic [7:0]  a;
    logic [15:0] m;
    for (int r = 0; r < NREG; r++)
    begin
      a = OFS_ENABLE + 8'(4 * r);
      m = IMPL_ALL[16 * r +: 16];
      bus(1'b0, a, 32'h0, 4'h3);
      check("enable reset", rd, 32'h0);
      bus(1'b1, a, 32'hffff_ffff, 4'h3);
      bus(1'b0, a, 32'h0, 4'h3);
      check("enable mask", rd, {16'h0, m});
      bus(1'b1, a, 32'h0000_5a5a, 4'h3);
      bus(1'b0, a, 32'h0, 4'h3);
      check("enable pattern", rd, {16'h0, m & 16'h5a5a});
    end
    do_reset();
    bus(1'b0, OFS_ENABLE + 8'h10, 32'h0, 4'h3);
    check("enable after reset", rd, 32'h0);
  endtask : t_regs

  // Unmapped, read-only flag region, clear region, byte lanes
  task automatic t_refuse();
    bus(1'b1, 8'h18, 32'h0000_ffff, 4'h3);
    bus(1'b0, 8'h18, 32'h0, 4'h3);
    check("unmapped", rd, 32'h0);
    bus(1'b1, OFS_FLAG, 32'h0000_ffff, 4'h3);
    bus(1'b0, OFS_FLAG, 32'h0, 4'h3);
    check("flag write", rd, 32'h0);
    bus(1'b0, OFS_CLEAR, 32'h0, 4'h3);
    check("clear read", rd, 32'h0);
    bus(1'b1, OFS_ENABLE + 8'h04, 32'h0000_ffff, 4'h1);
    bus(1'b0, OFS_ENABLE + 8'h04, 32'h0, 4'h3);
    check("low lane", rd, 32'h0000_00f3);
    bus(1'b1, OFS_ENABLE + 8'h04, 32'h0, 4'h3);
  endtask : t_refuse

  // One source: gate by enable, flag kept, priority off, clear
  task automatic t_irq(input int r, input int b);
    int          s;
    logic [7:0]  o;
    logic [31:0] bit_v;
    s = 16 * r + b;
    o = 8'(4 * r);
    bit_v = 32'h1 << b;
    bus(1'b1, OFS_ENABLE + o, bit_v, 4'h3);
    fire[s] <= 1'b1;
    tick(1);
    fire[s] <= 1'b0;
    tick(4);
    check("irq on", {31'h0, irq}, 32'h1);
    check("arb one-hot", {31'h0, arb_req === ({{(NSRC-1){1'b0}}, 1'b1} << s)}, 32'h1);
    bus(1'b0, OFS_FLAG + o, 32'h0, 4'h3);
    check("flag set", rd, bit_v);
    bus(1'b1, OFS_ENABLE + o, 32'h0, 4'h3);
    tick(3);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b0, OFS_FLAG + o, 32'h0, 4'h3);
    check("flag kept", rd, bit_v);
    bus(1'b1, OFS_ENABLE + o, bit_v, 4'h3);
    prio[3 * s +: 3] <= 3'h0;
    tick(3);
    check("prio off", {31'h0, arb_req[s]}, 32'h0);
    prio[3 * s +: 3] <= 3'h7;
    tick(3);
    check("prio on", {31'h0, irq}, 32'h1);
    check("prio copy", {31'h0, arb_prio === prio}, 32'h1);
    bus(1'b1, OFS_CLEAR + o, bit_v, 4'h3);
    tick(3);
    check("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'b0, OFS_FLAG + o, 32'h0, 4'h3);
    check("flag cleared", rd, 32'h0);
    bus(1'b1, OFS_ENABLE + o, 32'h0, 4'h3);
  endtask : t_irq

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_w = 32'h0;
    sel = 4'h0;
    fire = '0;
    prio = {NSRC{3'h1}};
    do_reset();
    t_regs();
    t_refuse();
    t_irq(0, 0);
    t_irq(2, 14);
    t_irq(5, 4);
    print_verdict();
  end
endmodule : iebk_top_tb
